// ==== verilog/ulfc_consts.vh ====
// register offsets, field positions, reset values and timing counts for the line format block
`ifndef ULFC_CONSTS_VH
`define ULFC_CONSTS_VH
// register offsets (3-bit address)
`define ULFC_OFS_DATA       3'h0
`define ULFC_OFS_IEN        3'h1
`define ULFC_OFS_IID        3'h2
`define ULFC_OFS_LFMT       3'h3
`define ULFC_OFS_MCTL       3'h4
`define ULFC_OFS_LSTATE     3'h5
`define ULFC_OFS_MSTATE     3'h6
`define ULFC_OFS_SCRATCH    3'h7
// line format field positions
`define ULFC_LF_LEN_LO      0
`define ULFC_LF_LEN_HI      1
`define ULFC_LF_STOP        2
`define ULFC_LF_PAR_ON      3
`define ULFC_LF_PAR_EVEN    4
`define ULFC_LF_STICK       5
`define ULFC_LF_BREAK       6
`define ULFC_LF_DIV_ACCESS  7
// line state field positions
`define ULFC_LS_READY       0
`define ULFC_LS_OVERRUN     1
`define ULFC_LS_PARITY_ERR  2
`define ULFC_LS_FRAME_ERR   3
`define ULFC_LS_HOLD_EMPTY  5
`define ULFC_LS_ALL_EMPTY   6
// reset values
`define ULFC_RST_BYTE       8'h00
`define ULFC_RST_DIVISOR    16'h0001
`define ULFC_IID_NONE       8'h01
// 16x clock ticks per bit time and per half bit
`define ULFC_TICKS_BIT      5'h10
`define ULFC_TICKS_HALF     5'h08
`endif

// ==== verilog/ulfc_fifo.v ====
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ulfc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             ref_clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg  [WIDTH-1:0] mem_q [0:DEPTH-1];  // flip-flop storage
  reg  [AW:0]      wr_q;               // write pointer with wrap bit
  reg  [AW:0]      rd_q;               // read pointer with wrap bit
  wire             full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire             empty = (wr_q == rd_q);
  wire             push  = in_valid && !full;
  wire             pop   = out_valid && out_ready;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  ////////////////////////////////////////////////////////////////////////////
  // pointers; storage has no reset since it is only read behind a valid
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
  always @(posedge ref_clk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule // ulfc_fifo
`default_nettype wire

// ==== verilog/ulfc_uart.v ====
// line format control, register select, transmitter and receiver of the serial port
`timescale 1ns/1ns
`default_nettype none
`include "ulfc_consts.vh"
module ulfc_uart #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire       ref_clk,
  input  wire       rst_b,
  input  wire [2:0] addr,
  input  wire       rd_en,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data_q,
  output reg        serial_out,
  input  wire       serial_in,
  output reg        tx_holding_empty,
  output reg        tx_all_empty,
  output reg        baud_tick_q
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0]  line_format_q;        // format, break and divisor access bits
  reg  [7:0]  interrupt_enable_q;   // stored only; interrupt logic lives elsewhere
  reg  [7:0]  modem_control_q;      // stored only
  reg  [7:0]  scratch_q;            // free byte for software
  reg  [15:0] divisor_q;            // baud divisor, high byte in 15:8
  reg  [15:0] baud_cnt_q;           // 16x tick divider
  reg  [7:0]  receive_buffer_q;     // last received character
  reg         rx_ready_q;           // character waiting in receive buffer
  reg         rx_overrun_q;         // sticky overrun
  reg         rx_par_err_q;         // sticky parity error
  reg         rx_frame_err_q;       // sticky framing error
  wire        div_access = line_format_q[`ULFC_LF_DIV_ACCESS];
  wire        wr_data_ofs = wr_en && (addr == `ULFC_OFS_DATA);
  wire        wr_ien_ofs  = wr_en && (addr == `ULFC_OFS_IEN);
  wire        wr_div_lo   = wr_data_ofs && div_access;
  wire        wr_div_hi   = wr_ien_ofs && div_access;
  wire        wr_holding  = wr_data_ofs && !div_access;
  wire        rd_lstate   = rd_en && (addr == `ULFC_OFS_LSTATE);
  wire        rd_rxbuf    = rd_en && (addr == `ULFC_OFS_DATA) && !div_access;
  // character length and parity helpers shared by both directions
  wire [3:0]  data_bits = 4'h5 + {2'b00, line_format_q[`ULFC_LF_LEN_HI:`ULFC_LF_LEN_LO]};
  wire        par_on    = line_format_q[`ULFC_LF_PAR_ON];
  wire        par_even  = line_format_q[`ULFC_LF_PAR_EVEN];
  wire        par_stick = line_format_q[`ULFC_LF_STICK];
  // masks unused upper data bits of a short character
  wire [7:0]  len_mask  = 8'hff >> (4'h8 - data_bits);
  // transmit fifo in front of the shifter
  wire [7:0]  fifo_out;
  wire        fifo_valid;
  wire        fifo_in_ready;
  reg         fifo_pop;
  ulfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txfifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_data   (wr_data),
    .in_valid  (wr_holding),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  ////////////////////////////////////////////////////////////////////////////
  // parity of a character under the current format
  function par_bit;
    input [7:0] d;
    begin
      if (par_stick)
        par_bit = ~par_even;
      else
        par_bit = ^d ^ ~par_even;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // host writes; divisor write reloads the baud counter at once
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_format_q      <= `ULFC_RST_BYTE;
      interrupt_enable_q <= `ULFC_RST_BYTE;
      modem_control_q    <= `ULFC_RST_BYTE;
      scratch_q          <= `ULFC_RST_BYTE;
      divisor_q          <= `ULFC_RST_DIVISOR;
    end else if (wr_en) begin
      case (addr)
        `ULFC_OFS_IEN: begin
          if (!div_access) interrupt_enable_q <= {4'h0, wr_data[3:0]};
        end
        `ULFC_OFS_LFMT:    line_format_q   <= wr_data;
        `ULFC_OFS_MCTL:    modem_control_q <= {3'b000, wr_data[4:0]};
        `ULFC_OFS_SCRATCH: scratch_q       <= wr_data;
        default: ;
      endcase
      if (wr_div_lo) divisor_q[7:0]  <= wr_data;
      if (wr_div_hi) divisor_q[15:8] <= wr_data;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // baud divider: one-cycle 16x tick; divisor 0 stops the tick
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_cnt_q  <= 16'h0000;
      baud_tick_q <= 1'b0;
    end else if (wr_div_lo || wr_div_hi) begin
      baud_cnt_q  <= 16'h0000;
      baud_tick_q <= 1'b0;
    end else if (baud_cnt_q + 16'h0001 >= divisor_q && divisor_q != 16'h0000) begin
      baud_cnt_q  <= 16'h0000;
      baud_tick_q <= 1'b1;
    end else begin
      baud_cnt_q  <= baud_cnt_q + 16'h0001;
      baud_tick_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // transmitter; states one-hot
  localparam [4:0] TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
                   TX_PAR  = 5'b01000, TX_STOP  = 5'b10000;
  reg  [4:0] tx_st_q;        // transmitter state
  reg  [7:0] tx_sh_q;        // data shifter, lsb goes out first
  reg        tx_par_q;       // parity of the character in flight
  reg  [3:0] tx_bits_q;      // data bits still to send
  reg  [5:0] tx_tick_q;      // 16x ticks left in this slot
  reg        tx_line_q;      // transmitter's own line level, break not applied
  // ticks for the stop interval: 16, 24 or 32
  wire [5:0] stop_ticks = !line_format_q[`ULFC_LF_STOP] ? 6'd16 :
                          (data_bits == 4'h5) ? 6'd24 : 6'd32;
  always @* begin
    // pop on the same tick that loads the shifter, idle or last stop tick
    fifo_pop = baud_tick_q && fifo_valid && (tx_st_q[0] || (tx_st_q[4] && tx_tick_q == 6'd1));
  end
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_q   <= TX_IDLE;
      tx_sh_q   <= 8'h00;
      tx_par_q  <= 1'b0;
      tx_bits_q <= 4'h0;
      tx_tick_q <= 6'd0;
      tx_line_q <= 1'b1;
    end else if (baud_tick_q) begin
      // the shifter runs whether or not a break is forced on the pin
      if (!tx_st_q[0] && tx_tick_q != 6'd1) begin
        tx_tick_q <= tx_tick_q - 6'd1;
      end else begin
        case (tx_st_q)
          TX_IDLE, TX_STOP: begin
            // a waiting character starts right after the stop slot, so back to back
            // characters carry no extra idle tick beyond the programmed stop length
            tx_line_q <= 1'b1;
            tx_st_q   <= TX_IDLE;
            if (fifo_valid) begin
              tx_sh_q   <= fifo_out & len_mask;
              tx_par_q  <= par_bit(fifo_out & len_mask);
              tx_bits_q <= data_bits;
              tx_line_q <= 1'b0;
              tx_tick_q <= 6'd16;
              tx_st_q   <= TX_START;
            end
          end
          TX_START, TX_DATA: begin
            if (tx_bits_q != 4'h0) begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
              tx_bits_q <= tx_bits_q - 4'h1;
              tx_tick_q <= 6'd16;
              tx_st_q   <= TX_DATA;
            end else if (par_on) begin
              tx_line_q <= tx_par_q;
              tx_tick_q <= 6'd16;
              tx_st_q   <= TX_PAR;
            end else begin
              tx_line_q <= 1'b1;
              tx_tick_q <= stop_ticks;
              tx_st_q   <= TX_STOP;
            end
          end
          TX_PAR: begin
            tx_line_q <= 1'b1;
            tx_tick_q <= stop_ticks;
            tx_st_q   <= TX_STOP;
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin and empty flags; break only masks the pin
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_out       <= 1'b1;
      tx_holding_empty <= 1'b1;
      tx_all_empty     <= 1'b1;
    end else begin
      serial_out       <= tx_line_q & ~line_format_q[`ULFC_LF_BREAK];
      tx_holding_empty <= !fifo_valid;
      tx_all_empty     <= !fifo_valid && tx_st_q[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // receiver: mid-bit sampling at 16x, checks first stop bit only
  localparam [3:0] RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000;
  reg  [3:0] rx_st_q;        // receiver state
  reg  [4:0] rx_tick_q;      // ticks to next sample point
  reg  [3:0] rx_bits_q;      // data plus parity slots left
  reg  [8:0] rx_sh_q;        // collected data and parity
  reg        rx_prev_q;      // line level last tick, for start edge
  wire [3:0] rx_slots = data_bits + {3'b000, par_on};
  // received data and parity, aligned from the shifter by the data plus parity slot count
  wire [8:0] rx_frame = rx_sh_q >> (4'h9 - rx_slots);
  wire [7:0] rx_word  = rx_frame[7:0] & len_mask;
  wire       rx_parv  = rx_frame[data_bits];
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q          <= RX_IDLE;
      rx_tick_q        <= 5'h00;
      rx_bits_q        <= 4'h0;
      rx_sh_q          <= 9'h000;
      rx_prev_q        <= 1'b1;
      receive_buffer_q <= 8'h00;
      rx_ready_q       <= 1'b0;
      rx_overrun_q     <= 1'b0;
      rx_par_err_q     <= 1'b0;
      rx_frame_err_q   <= 1'b0;
    end else begin
      // reads clear flags; a new event in the same cycle wins below
      if (rd_rxbuf) rx_ready_q <= 1'b0;
      if (rd_lstate) begin
        rx_overrun_q   <= 1'b0;
        rx_par_err_q   <= 1'b0;
        rx_frame_err_q <= 1'b0;
      end
      if (baud_tick_q) begin
        rx_prev_q <= serial_in;
        case (rx_st_q)
          RX_IDLE: begin
            if (rx_prev_q && !serial_in) begin
              rx_tick_q <= `ULFC_TICKS_HALF - 5'h01;
              rx_st_q   <= RX_START;
            end
          end
          RX_START: begin
            if (rx_tick_q != 5'h00) rx_tick_q <= rx_tick_q - 5'h01;
            else if (serial_in) rx_st_q <= RX_IDLE;  // false start rejected
            else begin
              rx_tick_q <= `ULFC_TICKS_BIT - 5'h01;
              rx_bits_q <= rx_slots;
              rx_st_q   <= RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_tick_q != 5'h00) rx_tick_q <= rx_tick_q - 5'h01;
            else begin
              rx_sh_q   <= {serial_in, rx_sh_q[8:1]};
              rx_bits_q <= rx_bits_q - 4'h1;
              rx_tick_q <= `ULFC_TICKS_BIT - 5'h01;
              if (rx_bits_q == 4'h1) rx_st_q <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_tick_q != 5'h00) rx_tick_q <= rx_tick_q - 5'h01;
            else begin
              // one stop checked, more are just idle line
              receive_buffer_q <= rx_word;
              rx_ready_q       <= 1'b1;
              if (rx_ready_q && !rd_rxbuf) rx_overrun_q <= 1'b1;
              if (par_on && rx_parv != par_bit(rx_word)) rx_par_err_q <= 1'b1;
              if (!serial_in) rx_frame_err_q <= 1'b1;
              rx_st_q <= RX_IDLE;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the read strobe
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `ULFC_OFS_DATA:    rd_data_q <= div_access ? divisor_q[7:0] : receive_buffer_q;
        `ULFC_OFS_IEN:     rd_data_q <= div_access ? divisor_q[15:8] : interrupt_enable_q;
        `ULFC_OFS_IID:     rd_data_q <= `ULFC_IID_NONE;
        `ULFC_OFS_LFMT:    rd_data_q <= line_format_q;
        `ULFC_OFS_MCTL:    rd_data_q <= modem_control_q;
        `ULFC_OFS_LSTATE:  rd_data_q <= {1'b0, !fifo_valid && tx_st_q[0], !fifo_valid, 1'b0,
                                         rx_frame_err_q, rx_par_err_q, rx_overrun_q, rx_ready_q};
        `ULFC_OFS_MSTATE:  rd_data_q <= 8'h00;
        `ULFC_OFS_SCRATCH: rd_data_q <= scratch_q;
        default:           rd_data_q <= 8'h00;
      endcase
    end
  end
endmodule // ulfc_uart
`default_nettype wire

// ==== verif/ulfc_uart_assertions.sv ====
// concurrent checks on the serial port's register and line pins
`timescale 1ns/1ns
`default_nettype none
module ulfc_uart_chk #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic [2:0] addr,
  input wire logic       rd_en,
  input wire logic       wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data_q,
  input wire logic       serial_out,
  input wire logic       serial_in,
  input wire logic       tx_holding_empty,
  input wire logic       tx_all_empty,
  input wire logic       baud_tick_q
);
  logic [7:0] lf_q;   // shadow of the line format register
  logic [7:0] ien_q;  // shadow of interrupt enable, upper nibble reads zero
  logic [7:0] scr_q;  // shadow of scratch
  logic [7:0] dlo_q;  // shadow divisor bytes
  logic [7:0] dhi_q;
  logic [1:0] age_q;  // cycles since reset, saturating
  wire        div_one  = {dhi_q, dlo_q} == 16'h0001;
  wire        div_zero = {dhi_q, dlo_q} == 16'h0000;
  ////////////////////////////////////////////////////////////
  // follow host writes as the address map decodes them
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lf_q  <= 8'h00;
      ien_q <= 8'h00;
      scr_q <= 8'h00;
      dlo_q <= 8'h01;
      dhi_q <= 8'h00;
      age_q <= 2'h0;
    end else begin
      if (age_q != 2'h3) age_q <= age_q + 2'h1;
      if (wr_en && addr == 3'h3) lf_q <= wr_data;
      if (wr_en && addr == 3'h7) scr_q <= wr_data;
      if (wr_en && addr == 3'h0 && lf_q[7]) dlo_q <= wr_data;
      if (wr_en && addr == 3'h1 && lf_q[7]) dhi_q <= wr_data;
      if (wr_en && addr == 3'h1 && !lf_q[7]) ien_q <= {4'h0, wr_data[3:0]};
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_lf_read: assert property (rd_en && addr == 3'h3 |=> rd_data_q == $past(lf_q))
    else $error("line format readback wrong");
  chk_div_low: assert property (rd_en && addr == 3'h0 && lf_q[7] |=> rd_data_q == $past(dlo_q))
    else $error("divisor low byte readback wrong");
  chk_div_high: assert property (rd_en && addr == 3'h1 && lf_q[7] |=> rd_data_q == $past(dhi_q))
    else $error("divisor high byte readback wrong");
  chk_ien_read: assert property (rd_en && addr == 3'h1 && !lf_q[7] |=> rd_data_q == $past(ien_q))
    else $error("interrupt enable readback wrong");
  chk_scr_read: assert property (rd_en && addr == 3'h7 |=> rd_data_q == $past(scr_q))
    else $error("scratch readback wrong");
  chk_break_low: assert property (lf_q[6] && $past(lf_q[6]) |-> !serial_out)
    else $error("line not spacing during break");
  chk_idle_mark: assert property (tx_all_empty && $past(tx_all_empty) && !lf_q[6] && !$past(lf_q[6])
    |-> serial_out)
    else $error("idle line not marking");
  chk_reset_mark: assert property ($rose(rst_b) |-> serial_out && tx_all_empty && rd_data_q == 8'h00)
    else $error("reset state wrong");
  chk_empty_nest: assert property (tx_all_empty |-> tx_holding_empty)
    else $error("all empty while holding busy");
  chk_tick_one: assert property (age_q == 2'h3 && div_one && $past(div_one) && $past(div_one, 2)
    && !$past(wr_en && lf_q[7] && (addr == 3'h0 || addr == 3'h1)) |-> baud_tick_q)
    else $error("divisor one missed a tick");
  chk_tick_stop: assert property (div_zero && $past(div_zero) && $past(div_zero, 2) |-> !baud_tick_q)
    else $error("divisor zero still ticks");
  cov_break: cover property (lf_q[6] && !serial_out);
  cov_div_rd: cover property (rd_en && addr == 3'h0 && lf_q[7]);
  cov_stall: cover property (div_zero && !tx_holding_empty);
endmodule // ulfc_uart_chk
bind ulfc_uart ulfc_uart_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
  .wr_data(wr_data), .rd_data_q(rd_data_q), .serial_out(serial_out), .serial_in(serial_in),
  .tx_holding_empty(tx_holding_empty), .tx_all_empty(tx_all_empty), .baud_tick_q(baud_tick_q));
`default_nettype wire

// ==== verif/ulfc_line_peer.sv ====
// far end of the serial line: frames characters onto the receive pin
`timescale 1ns/1ns
`default_nettype none
module ulfc_line_peer (
  input  wire logic ref_clk,
  output var  logic line_q
);
  initial line_q = 1'b1;  // marking level while idle
  // one bit per sixteen clocks, valid only at divisor one
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line_q = bits[i];
      repeat (16) @(negedge ref_clk);
    end
    line_q = 1'b1;  // release to mark, as the pull-up would
  endtask
endmodule // ulfc_line_peer
`default_nettype wire

// ==== verif/test_uart_line_format_control.sv ====
// self-checking bench for the serial port's line format control
`timescale 1ns/1ns
`default_nettype none
module test_uart_line_format_control;
  logic       ref_clk = 1'b0;
  logic       rst_b   = 1'b0;
  logic       rd_en   = 1'b0;
  logic       wr_en   = 1'b0;
  logic [2:0] addr    = 3'h0;
  logic [7:0] wr_data = 8'h00;
  wire  [7:0] rd_data_q;
  wire        serial_out, serial_in, thr_e, all_e, tick;
  int         fails = 0, tests_run = 0, cyc = 0, t_fall = 0;
  // rows: format, data, expected stop length in clocks
  logic [23:0] rows [8] = '{24'h00_1510, 24'h04_0A18, 24'h05_2C20, 24'h0A_5510,
                            24'h1B_A510, 24'h2B_3C10, 24'h3A_7E10, 24'h07_C320};
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc++;
  ulfc_uart dut (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data_q(rd_data_q), .serial_out(serial_out), .serial_in(serial_in),
    .tx_holding_empty(thr_e), .tx_all_empty(all_e), .baud_tick_q(tick));
  ulfc_line_peer peer (.ref_clk(ref_clk), .line_q(serial_in));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // host cycles: strobe for one clock, driven on the falling edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge ref_clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge ref_clk);
    rd_en = 1'b0;
    v = rd_data_q;
  endtask
  // bounded waits; a timeout shows up as a mismatch
  task automatic wait_line(input logic lvl);
    int k = 0;
    while (serial_out !== lvl && k < 4000) begin
      @(negedge ref_clk);
      k++;
    end
    t_fall = cyc;
    chk("line level", 16'(lvl), 16'(serial_out));
  endtask
  task automatic wait_all(output int k);
    k = 0;
    while (all_e !== 1'b1 && k < 4000) begin
      @(negedge ref_clk);
      k++;
    end
    chk("all empty", 16'h0001, 16'(all_e));
  endtask
  // expected frame with one stop: {length, bits from start upward}
  function automatic logic [15:0] frame(input logic [7:0] lf, input logic [7:0] d);
    int n;
    logic [11:0] b;
    logic p;
    n = 5 + lf[1:0];
    b = 12'hfff;
    b[0] = 1'b0;
    for (int i = 0; i < n; i++) b[i+1] = d[i];
    p = lf[5] ? ~lf[4] : ^(d & ~(8'hff << n)) ^ ~lf[4];
    if (lf[3]) b[n+1] = p;
    return {4'(n + 2 + lf[3]), b};
  endfunction
  // two characters back to back: bits of the first, start to start gap
  task automatic tx(input logic [7:0] lf, input logic [7:0] d, input int stops);
    logic [15:0] f;
    int t, k;
    f = frame(lf, d);
    wr(3'h3, lf);
    wr(3'h0, d);
    fork
      wr(3'h0, d);
      wait_line(1'b0);
    join
    t = t_fall;
    for (int i = 0; i < f[15:12]; i++) begin
      while (cyc < t + 8 + 16 * i) @(negedge ref_clk);
      chk("tx bit", 16'(f[i]), 16'(serial_out));
    end
    wait_line(1'b0);
    chk("char period", 16'(16 * (f[15:12] - 1) + stops), 16'(t_fall - t));
    wait_all(k);
  endtask
  task automatic rx(input logic [7:0] lf, input logic [7:0] d, input logic [11:0] flip, input logic [1:0] err);
    logic [15:0] f;
    logic [7:0] v;
    f = frame(lf, d);
    wr(3'h3, lf);
    peer.send(f[11:0] ^ flip, f[15:12]);
    repeat (16) @(negedge ref_clk);
    rd(3'h5, v);
    chk("rx errors", 16'(err), 16'(v[3:2]));
    rd(3'h0, v);
    chk("rx data", 16'(d & ~(8'hff << (5 + lf[1:0]))), 16'(v));
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [15:0] f;
    int k;
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    chk("idle after reset", 16'h0003, 16'({serial_out, all_e}));
    rd(3'h3, v);
    chk("format reset", 16'h0000, 16'(v));
    for (int r = 0; r < 8; r++) begin
      tx(rows[r][23:16], rows[r][15:8], rows[r][7:0]);
      rx(rows[r][23:16], rows[r][15:8], 12'h000, 2'b00);
    end
    rx(8'h0B, 8'h55, 12'h200, 2'b01);
    rx(8'h2B, 8'h00, 12'h200, 2'b01);
    rx(8'h03, 8'h81, 12'h200, 2'b10);
    // two-stop format, peer sends single stops back to back
    f = frame(8'h07, 8'h96);
    wr(3'h3, 8'h07);
    peer.send(f[11:0], f[15:12]);
    peer.send(f[11:0], f[15:12]);
    repeat (16) @(negedge ref_clk);
    rd(3'h5, v);
    chk("first stop only", 16'h0063, 16'(v));
    // register map, both settings of the access bit
    wr(3'h3, 8'h9B);
    rd(3'h3, v);
    chk("format readback", 16'h009B, 16'(v));
    wr(3'h0, 8'h12);
    wr(3'h1, 8'h34);
    rd(3'h0, v);
    chk("divisor low", 16'h0012, 16'(v));
    rd(3'h1, v);
    chk("divisor high", 16'h0034, 16'(v));
    wr(3'h3, 8'h1B);
    wr(3'h1, 8'h0F);
    rd(3'h1, v);
    chk("interrupt enable", 16'h000F, 16'(v));
    rd(3'h0, v);
    chk("receive buffer", 16'h0096, 16'(v));
    wr(3'h2, 8'hFF);
    rd(3'h2, v);
    chk("identity read only", 16'h0001, 16'(v));
    wr(3'h7, 8'hA5);
    rd(3'h7, v);
    chk("scratch", 16'h00A5, 16'(v));
    wr(3'h4, 8'hFF);
    rd(3'h4, v);
    chk("modem control", 16'h001F, 16'(v));
    wr(3'h3, 8'h80);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h01);
    // break: pad char first, break once it left the holding side, timed by the shifter
    wr(3'h3, 8'h00);
    wr(3'h0, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk("pad taken", 16'h0001, 16'(thr_e));
    wr(3'h3, 8'h40);
    wait_all(k);
    // idle shifter would mark here, so only the break keeps the pin low
    chk("break level", 16'h0000, 16'(serial_out));
    chk("break timer", 16'h0001, 16'(k + 5 >= 100 && k + 5 <= 140));
    wr(3'h3, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk("break released", 16'h0001, 16'(serial_out));
    // stall with divisor zero, overfill the buffer, then drain
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h00);
    repeat (17) wr(3'h0, 8'h11);
    chk("buffer held", 16'h0000, 16'(thr_e));
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h01);
    wait_all(k);
    chk("sixteen kept", 16'h0001, 16'(k >= 1790 && k <= 1840));
    // second reset in mid run
    @(negedge ref_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    rd(3'h3, v);
    chk("format after reset", 16'h0000, 16'(v));
    stop_test();
  end
  // watchdog sized well past the expected run length
  initial begin
    #(40 * 60000);
    fails++;
    $display("[FAIL] watchdog expected done seen hang");
    stop_test();
  end
endmodule // test_uart_line_format_control
`default_nettype wire
